// *** hw/host_port.sv ***
// parallel host port, reset routing and supply board glue
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "host_port_regs.svh"
`default_nettype none

module host_port (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// parallel host link
	input wire logic [7:0] host_data,
	input wire logic strobe_n,
	input wire logic init_n,
	output logic busy,
	output logic ack_n,
	// reset sources and outputs
	input wire logic supply_low_n,
	input wire logic ext_reset_n,
	output logic forced_reset_out,
	output logic motor_error_reset_out,
	output logic cpu_reset_input_n,
	output logic host_init_interrupt,
	// supply board
	input wire logic supply_off_notice,
	input wire logic current_limit_flag,
	input wire logic head_driver_error,
	output logic power_down_request
);

	// ------------------------------------------------------------
	// reset combination and stretch
	// ------------------------------------------------------------
	logic [15:0] rst_cnt_r, rst_cnt_nxt;
	logic rst_src;
	logic frc_r, frc_nxt;
	logic mot_r, mot_nxt;
	logic pd_r, pd_nxt;
	logic off_sync_r;

	// supply low, end of the power off notice, external request or forced outputs
	assign rst_src = !supply_low_n || !ext_reset_n || frc_r || mot_r
		|| (off_sync_r && !supply_off_notice);

	always_comb begin
		rst_cnt_nxt = rst_cnt_r;
		if (rst_src) begin
			rst_cnt_nxt = 16'(`RST_HOLD_CYC);
		end else if (rst_cnt_r != 16'h0000) begin
			rst_cnt_nxt = rst_cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rst_cnt_r <= 16'(`RST_HOLD_CYC);
			off_sync_r <= 1'b0;
		end else begin
			rst_cnt_r <= rst_cnt_nxt;
			off_sync_r <= supply_off_notice;
		end
	end

	// own reset from the stretched pulse, same as the cpu sees
	logic blk_rst;
	assign blk_rst = (rst_cnt_r != 16'h0000);
	assign cpu_reset_input_n = !blk_rst;

	// ------------------------------------------------------------
	// strobe synchroniser and init forward
	// ------------------------------------------------------------
	logic stb_meta_r, stb_sync_r, stb_prev_r;
	logic init_meta_r, init_sync_r;
	logic stb_fall;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stb_meta_r <= 1'b1;
			stb_sync_r <= 1'b1;
			stb_prev_r <= 1'b1;
			init_meta_r <= 1'b1;
			init_sync_r <= 1'b1;
		end else begin
			stb_meta_r <= strobe_n;
			stb_sync_r <= stb_meta_r;
			stb_prev_r <= stb_sync_r;
			init_meta_r <= init_n;
			init_sync_r <= init_meta_r;
		end
	end

	assign stb_fall = stb_prev_r && !stb_sync_r;
	assign host_init_interrupt = !init_sync_r;

	// ------------------------------------------------------------
	// two-entry byte buffer
	// ------------------------------------------------------------
	host_port_pkg::host_byte_type buf_r [2];
	host_port_pkg::host_byte_type buf_nxt [2];
	logic [1:0] cnt_r, cnt_nxt;
	logic wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic in_valid, in_ready, out_valid, out_ready;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);

	always_comb begin
		buf_nxt = buf_r;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		cnt_nxt = cnt_r;
		if (in_valid && in_ready) begin
			buf_nxt[wr_ptr_r].data = host_data;
			wr_ptr_nxt = !wr_ptr_r;
		end
		if (out_valid && out_ready) begin
			rd_ptr_nxt = !rd_ptr_r;
		end
		cnt_nxt = cnt_r + 2'((in_valid && in_ready) ? 1 : 0)
			- 2'((out_valid && out_ready) ? 1 : 0);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			buf_r[0] <= '0;
			buf_r[1] <= '0;
			cnt_r <= 2'h0;
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
		end else if (blk_rst) begin
			cnt_r <= 2'h0;
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
		end else begin
			buf_r <= buf_nxt;
			cnt_r <= cnt_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
		end
	end

	// ------------------------------------------------------------
	// handshake state machine
	// ------------------------------------------------------------
	host_port_pkg::handshake_state_type hs_r, hs_nxt;
	logic [15:0] ack_cnt_r, ack_cnt_nxt;
	logic force_r, force_nxt;
	logic release_req, data_rd;

	assign data_rd = reg_rd && (reg_addr == `REG_DATA);
	assign out_ready = data_rd;
	assign release_req = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_RELEASE_BIT];
	// a strobe is only taken while idle and with room in the buffer
	assign in_valid = stb_fall && (hs_r == host_port_pkg::HS_IDLE);

	always_comb begin
		hs_nxt = hs_r;
		ack_cnt_nxt = ack_cnt_r;
		force_nxt = force_r;
		if (reg_wr && reg_addr == `REG_CTRL) begin
			if (reg_wdata[`CTRL_FORCE_BUSY_BIT]) begin
				force_nxt = 1'b1;
			end else if (reg_wdata[`CTRL_CLEAR_FORCE_BIT]) begin
				force_nxt = 1'b0;
			end
		end
		case (hs_r)
			host_port_pkg::HS_IDLE: begin
				if (in_valid && in_ready) begin
					hs_nxt = host_port_pkg::HS_HELD;
				end
			end
			host_port_pkg::HS_HELD: begin
				if (release_req) begin
					hs_nxt = host_port_pkg::HS_ACK;
					ack_cnt_nxt = 16'(`ACK_PULSE_CYC);
				end
			end
			host_port_pkg::HS_ACK: begin
				ack_cnt_nxt = ack_cnt_r - 16'h0001;
				if (ack_cnt_r == 16'h0001) begin
					hs_nxt = host_port_pkg::HS_IDLE;
				end
			end
			default: begin
				hs_nxt = host_port_pkg::HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hs_r <= host_port_pkg::HS_IDLE;
			ack_cnt_r <= 16'h0000;
			force_r <= 1'b0;
		end else if (blk_rst) begin
			hs_r <= host_port_pkg::HS_IDLE;
			ack_cnt_r <= 16'h0000;
			force_r <= 1'b0;
		end else begin
			hs_r <= hs_nxt;
			ack_cnt_r <= ack_cnt_nxt;
			force_r <= force_nxt;
		end
	end

	// busy drops with the acknowledge; force, full buffer or reset hold it
	assign busy = (hs_r == host_port_pkg::HS_HELD) || force_r || !in_ready
		|| blk_rst;
	assign ack_n = (hs_r != host_port_pkg::HS_ACK);

	// ------------------------------------------------------------
	// reset control and power down register
	// ------------------------------------------------------------
	always_comb begin
		frc_nxt = frc_r;
		mot_nxt = mot_r;
		pd_nxt = pd_r;
		if (reg_wr && reg_addr == `REG_RSTCTL) begin
			frc_nxt = reg_wdata[`RST_FORCE_BIT];
			mot_nxt = reg_wdata[`RST_MOTOR_BIT];
			pd_nxt = reg_wdata[`RST_PD_BIT];
		end else if (frc_r || mot_r) begin
			frc_nxt = 1'b0;
			mot_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			frc_r <= 1'b0;
			mot_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			frc_r <= frc_nxt;
			mot_r <= mot_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign forced_reset_out = frc_r;
	assign motor_error_reset_out = mot_r;
	assign power_down_request = pd_r;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [7:0] rdata_r, rdata_nxt;
	host_port_pkg::supply_status_type sup;

	assign sup = '{supply_low_n, supply_off_notice, current_limit_flag, head_driver_error};

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`REG_DATA: rdata_nxt = buf_r[rd_ptr_r].data;
				`REG_STAT: begin
					rdata_nxt[`STAT_BUSY_BIT] = busy;
					rdata_nxt[`STAT_VALID_BIT] = out_valid;
					rdata_nxt[`STAT_FORCE_BIT] = force_r;
					rdata_nxt[`STAT_INIT_BIT] = host_init_interrupt;
					rdata_nxt[`STAT_OFF_BIT] = sup.supply_off_notice;
					rdata_nxt[`STAT_CL_BIT] = !sup.current_limit_flag;
					rdata_nxt[`STAT_HEAD_DRIVER_ERROR_BIT] = sup.head_driver_error;
					rdata_nxt[`STAT_PD_BIT] = pd_r;
				end
				`REG_RSTCTL: rdata_nxt = {5'h00, pd_r, mot_r, frc_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

endmodule : host_port

`default_nettype wire

// *** hw/host_port_pkg.sv ***
// types of the host port block
package host_port_pkg;

	typedef struct packed {
		logic [7:0] data;
	} host_byte_type;

	typedef struct packed {
		logic supply_low_n;
		logic supply_off_notice;
		logic current_limit_flag;
		logic head_driver_error;
	} supply_status_type;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_HELD = 3'b010,
		HS_ACK = 3'b100
	} handshake_state_type;

endpackage : host_port_pkg

// *** hw/host_port_regs.svh ***
// register offsets, field positions and timing counts of the host port block
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// register offsets (word addresses on the plain port)
`define REG_DATA 4'h0
`define REG_CTRL 4'h1
`define REG_STAT 4'h2
`define REG_RSTCTL 4'h3

// control register fields (write effects)
`define CTRL_RELEASE_BIT 0
`define CTRL_FORCE_BUSY_BIT 1
`define CTRL_CLEAR_FORCE_BIT 2

// status register fields
`define STAT_BUSY_BIT 0
`define STAT_VALID_BIT 1
`define STAT_FORCE_BIT 2
`define STAT_INIT_BIT 3
`define STAT_OFF_BIT 4
`define STAT_CL_BIT 5
`define STAT_HEAD_DRIVER_ERROR_BIT 6
`define STAT_PD_BIT 7

// reset control register fields
`define RST_FORCE_BIT 0
`define RST_MOTOR_BIT 1
`define RST_PD_BIT 2

// timing: clock 100 MHz
`define CLK_PERIOD_NS 10
`define ACK_PULSE_NS 5000
`define ACK_PULSE_CYC ((`ACK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_HOLD_NS 20000
`define RST_HOLD_CYC ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CPU_CLK_KHZ 24570

`endif

// *** sim/host_model.sv ***
// host computer model driving the parallel link
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// clock
	input wire logic clk_sys,
	// parallel link
	output logic [7:0] host_data,
	output logic strobe_n
);
	initial begin
		host_data = 8'h00;
		strobe_n = 1'b1;
	end
	// data steady around the strobe, scrambled afterwards
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys);
		host_data <= b;
		@(posedge clk_sys);
		strobe_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		strobe_n <= 1'b1;
		@(posedge clk_sys);
		host_data <= ~b;
	endtask : send
endmodule : host_model
`default_nettype wire

// *** sim/host_port_properties.sv ***
// concurrent checks on the host port block ports
`timescale 1ns/10ps
`include "host_port_regs.svh"
`default_nettype none
module host_port_properties (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// host link and reset outputs
	input wire logic strobe_n,
	input wire logic init_n,
	input wire logic busy,
	input wire logic ack_n,
	input wire logic forced_reset_out,
	input wire logic motor_error_reset_out,
	input wire logic cpu_reset_input_n,
	input wire logic host_init_interrupt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [11:0] low_r, low_nxt, held_r, held_nxt;
	logic rel_wr, frc_wr, frc_out;
	assign rel_wr = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_RELEASE_BIT];
	assign frc_wr = reg_wr && reg_addr == `REG_RSTCTL && reg_wdata[`RST_FORCE_BIT];
	assign frc_out = forced_reset_out | motor_error_reset_out;
	// lengths of the acknowledge pulse and of the cpu reset
	always_comb begin
		low_nxt = ack_n ? 12'h000 : low_r + 12'h001;
		held_nxt = cpu_reset_input_n ? 12'h000 : held_r + 12'h001;
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			low_r <= 12'h000;
			held_r <= 12'h000;
		end else begin
			low_r <= low_nxt;
			held_r <= held_nxt;
		end
	end
	chk_strobe_sets_busy: assert property ($fell(strobe_n) && !busy && ack_n && cpu_reset_input_n
		|-> ##[1:5] busy) else $error("busy did not follow strobe");
	chk_ack_width: assert property ($rose(ack_n) |-> low_r == 12'h1f4)
		else $error("acknowledge pulse length wrong");
	chk_ack_cause: assert property ($fell(ack_n) |-> $past(rel_wr))
		else $error("acknowledge without release write");
	chk_busy_release: assert property ($fell(ack_n) |-> !busy)
		else $error("busy still high at acknowledge");
	chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_init_forward: assert property ($fell(init_n) |-> ##[1:3] host_init_interrupt)
		else $error("init not forwarded");
	chk_reset_busy: assert property (!cpu_reset_input_n |-> busy)
		else $error("busy low during reset");
	chk_reset_hold: assert property ($rose(cpu_reset_input_n) |-> held_r >= 12'h7d0)
		else $error("reset released too early");
	chk_forced_pulse: assert property (frc_wr |=> forced_reset_out ##1 !forced_reset_out)
		else $error("forced reset pulse wrong");
	chk_forced_reset: assert property ($rose(frc_out) |-> ##[0:3] !cpu_reset_input_n)
		else $error("forced reset did not reach cpu");
	cover property ($rose(ack_n));
	cover property ($rose(motor_error_reset_out));
	cover property ($rose(host_init_interrupt));
endmodule : host_port_properties
bind host_port host_port_properties chk_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .strobe_n, .init_n, .busy, .ack_n, .forced_reset_out,
	.motor_error_reset_out, .cpu_reset_input_n, .host_init_interrupt);
`default_nettype wire

// *** sim/printer_host_port_and_reset_tb.sv ***
// self-checking testbench of the host port block
`timescale 1ns/10ps
`include "host_port_regs.svh"
`default_nettype none
module printer_host_port_and_reset_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic init_n = 1'b1;
	logic supply_low_n = 1'b1;
	logic ext_reset_n = 1'b1;
	logic supply_off_notice = 1'b0;
	logic current_limit_flag = 1'b1;
	logic head_driver_error = 1'b0;
	logic [7:0] reg_rdata, host_data;
	logic strobe_n, busy, ack_n, forced_reset_out, motor_error_reset_out;
	logic cpu_reset_input_n, host_init_interrupt, power_down_request;
	int error_cnt = 0;
	int n_tests = 0;
	int n;
	always #5 clk_sys = ~clk_sys;
	host_port dut_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.host_data, .strobe_n, .init_n, .busy, .ack_n, .supply_low_n, .ext_reset_n,
		.forced_reset_out, .motor_error_reset_out, .cpu_reset_input_n, .host_init_interrupt,
		.supply_off_notice, .current_limit_flag, .head_driver_error, .power_down_request);
	host_model host_u (.clk_sys, .host_data, .strobe_n);
	task automatic close_out();
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata, e);
	endtask : rdc
	// bounded wait for ack_n or the cpu reset to go high, cycles counted
	task automatic wait_hi(input bit rst_sel, output int k);
		k = 0;
		while ((rst_sel ? cpu_reset_input_n : ack_n) !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		if (k == 3000) begin
			error_cnt++;
			$display("wrong value at %0t: wait ran out", $time);
			close_out();
		end
	endtask : wait_hi
	task automatic s_byte();
		host_u.send(8'ha5);
		tick(2);
		rdc(`REG_STAT, 8'h03);
		rdc(`REG_DATA, 8'ha5);
		host_u.send(8'h5a);
		tick(4);
		rdc(`REG_STAT, 8'h01);
		wr(`REG_CTRL, 8'h01);
		cmp({6'h00, busy, ack_n}, 8'h00);
		wait_hi(1'b0, n);
		cmp(8'(n == 500), 8'h01);
	endtask : s_byte
	// one print item: a code byte and two attribute bytes, each acknowledged
	task automatic s_item();
		for (int i = 0; i < 3; i++) begin
			host_u.send(8'h41 + 8'(i));
			tick(2);
			rdc(`REG_DATA, 8'h41 + 8'(i));
			wr(`REG_CTRL, 8'h01);
			cmp({6'h00, busy, ack_n}, 8'h00);
			wait_hi(1'b0, n);
			cmp(8'(n == 500), 8'h01);
		end
	endtask : s_item
	task automatic s_force();
		wr(`REG_CTRL, 8'h02);
		cmp({7'h00, busy}, 8'h01);
		wr(`REG_CTRL, 8'h06);
		rdc(`REG_STAT, 8'h05);
		wr(`REG_CTRL, 8'h04);
		cmp({7'h00, busy}, 8'h00);
	endtask : s_force
	task automatic s_misc();
		@(posedge clk_sys);
		init_n <= 1'b0;
		tick(4);
		rdc(`REG_STAT, 8'h08);
		cmp({7'h00, host_init_interrupt}, 8'h01);
		@(posedge clk_sys);
		init_n <= 1'b1;
		wr(4'hf, 8'hff);
		rdc(4'hf, 8'h00);
		wr(`REG_RSTCTL, 8'h04);
		cmp({7'h00, power_down_request}, 8'h01);
		rdc(`REG_STAT, 8'h80);
		wr(`REG_RSTCTL, 8'h00);
	endtask : s_misc
	// supply board status, power down, and the reset when the off notice ends
	task automatic s_supply();
		@(posedge clk_sys);
		supply_off_notice <= 1'b1;
		current_limit_flag <= 1'b0;
		head_driver_error <= 1'b1;
		rdc(`REG_STAT, 8'h70);
		wr(`REG_RSTCTL, 8'h04);
		rdc(`REG_STAT, 8'hf0);
		@(posedge clk_sys);
		supply_off_notice <= 1'b0;
		current_limit_flag <= 1'b1;
		head_driver_error <= 1'b0;
		tick(3);
		cmp({7'h00, cpu_reset_input_n}, 8'h00);
		wait_hi(1'b1, n);
		cmp(8'(n > 1990), 8'h01);
		wr(`REG_RSTCTL, 8'h00);
		rdc(`REG_RSTCTL, 8'h00);
	endtask : s_supply
	// forced, motor-error, external and supply resets in turn
	task automatic s_resets();
		wr(`REG_CTRL, 8'h02);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			reg_addr <= `REG_RSTCTL;
			reg_wdata <= {6'h00, i == 1, i == 0};
			reg_wr <= (i < 2);
			ext_reset_n <= (i != 2);
			supply_low_n <= (i != 3);
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			repeat (2) @(posedge clk_sys);
			ext_reset_n <= 1'b1;
			supply_low_n <= 1'b1;
			tick(3);
			cmp({7'h00, cpu_reset_input_n}, 8'h00);
			wait_hi(1'b1, n);
			cmp(8'(n > 1990), 8'h01);
		end
		rdc(`REG_STAT, 8'h00);
	endtask : s_resets
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		tick(1);
		cmp({6'h00, busy, cpu_reset_input_n}, 8'h02);
		wait_hi(1'b1, n);
		cmp(8'(n >= 1990), 8'h01);
		s_byte();
		s_item();
		s_force();
		s_misc();
		s_supply();
		s_resets();
		close_out();
	end
endmodule : printer_host_port_and_reset_tb
`default_nettype wire
